// >>> astx_pkg.sv
// package with register map, field layout and timing constants
package astx_pkg;
   // Overview of operation
   // - holding register write starts a transmission
   // - empty shift register loads character at once
   // - busy shifter: hold, load right after stop
   // - start, data, stop follow load immediately
   // - polarity invert flips idle and data levels
   // - polarity acts in asynchronous mode only
   // - buffer free while enabled and nothing queued
   // - buffer free flag valid second cycle later
   // - buffer free flag is read only
   // - interrupt gated by enable, flag unaffected
   // - shift empty bit 1 tracks shifter occupancy
   // - shift empty is read only, no interrupt
   // - ninth bit at bit 0 is sent
   // - synchronous receive enables override transmit enable

   localparam logic [7:0] ASTX_ADDR_DATA    = 8'h00; // tx_holding_reg
   localparam logic [7:0] ASTX_ADDR_STATUS  = 8'h04; // tx_status_control
   localparam logic [7:0] ASTX_ADDR_CONTROL = 8'h08; // enables and modes
   localparam logic [7:0] ASTX_ADDR_BAUD    = 8'h0C; // baud divisor
   localparam logic [7:0] ASTX_ADDR_IRQ_ST  = 8'h10; // sticky events
   localparam logic [7:0] ASTX_ADDR_IRQ_EN  = 8'h14; // event mask

   // tx_status_control fields
   localparam int ASTX_ST_NINTH    = 0;
   localparam int ASTX_ST_EMPTY    = 1;
   localparam int ASTX_ST_NINE_EN  = 6;
   // control fields
   localparam int ASTX_CT_TX_ENABLE     = 0;
   localparam int ASTX_CT_CLOCKED  = 1;
   localparam int ASTX_CT_PORT_ON  = 2;
   localparam int ASTX_CT_INVERT   = 3;
   localparam int ASTX_CT_SINGLE_RECEIVE_EN     = 4;
   localparam int ASTX_CT_CONTINUOUS_RECEIVE_EN     = 5;
   localparam int ASTX_CT_IRQ_EN   = 6;
   // status-read free bit and event bits
   localparam int ASTX_ST_FREE     = 7;
   localparam int ASTX_EV_FREE     = 0;
   localparam int ASTX_EV_DONE     = 1;

   localparam int ASTX_DATA_BITS   = 8;
   localparam int ASTX_BAUD_W      = 16;
   localparam logic [15:0] ASTX_BAUD_RESET = 16'h00D9;
   localparam int ASTX_FLAG_DELAY  = 2;   // cycles after holding write
   localparam int ASTX_EVENTS      = 2;
endpackage

// >>> astx_flag_delay.sv
`timescale 1ns/10ps
// delays a level by a fixed number of clock cycles
module astx_flag_delay #(
   parameter int DEPTH = 2
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // level in and delayed level out
   input  wire logic din,
   output logic      dout
);
   logic [DEPTH-1:0] pipe;

   // shift register; resets to low so flag starts clear
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pipe <= '0;
      end else begin
         pipe <= {pipe[DEPTH-2:0], din};
      end
   end
   assign dout = pipe[DEPTH-1];
endmodule

// >>> astx_baud_tick.sv
`timescale 1ns/10ps
// baud period tick generator, restarts on demand
module astx_baud_tick #(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         reset_n,
   // control
   input  wire logic         restart,
   input  wire logic [W-1:0] divisor,
   // one-cycle tick at end of each bit period
   output logic              tick
);
   logic [W-1:0] count;

   // count down divisor..0; a registered tick would stretch the first
   // bit after a restart by one cycle, so tick is decoded from count
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         count <= '0;
      end else if (restart || count == '0) begin
         count <= divisor;
      end else begin
         count <= count - 1'b1;
      end
   end

   // every bit, the start bit included, lasts divisor+1 cycles
   assign tick = (count == '0);
endmodule

// >>> astx_top.sv
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
// asynchronous serial transmitter with apb register file
module astx_top (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // serial line
   output logic             tx_out,
   output logic             tx_oe_n,
   // interrupt
   output logic             irq
);
   import astx_pkg::*;

   typedef enum logic [1:0] {
      ASTX_IDLE,
      ASTX_START,
      ASTX_DATA,
      ASTX_STOP
   } astx_phase_e;

   typedef struct packed {
      logic [31:0]                 prdata;
      logic                        pready;
      logic                        pslverr;
      logic                        tx_out;
      logic                        tx_oe_n;
      logic                        irq;
      logic [ASTX_DATA_BITS-1:0]   hold_data;
      logic                        hold_ninth;
      logic                        hold_full;
      logic [ASTX_DATA_BITS:0]     shift;
      logic [3:0]                  bit_cnt;
      astx_phase_e                 phase;
      logic                        ninth_bit;
      logic                        nine_en;
      logic [6:0]                  ctrl;
      logic [ASTX_BAUD_W-1:0]      baud;
      logic [ASTX_EVENTS-1:0]      ev_status;
      logic [ASTX_EVENTS-1:0]      ev_mask;
      logic                        free_prev;
   } astx_state_s;

   astx_state_s st;
   astx_state_s next_st;

   logic tick;
   logic restart;
   logic free_raw;
   logic free_flag;
   logic tx_on;
   logic async_mode;
   logic port_on;
   logic line_bit;
   logic wr_access;
   logic rd_access;

   // bit timing, restarted whenever a character enters the shifter
   astx_baud_tick #(
      .W(ASTX_BAUD_W)
   ) u_tick (
      .clk     (clk),
      .reset_n (reset_n),
      .restart (restart),
      .divisor (st.baud),
      .tick    (tick)
   );

   // flag settles two cycles after the holding write
   astx_flag_delay #(
      .DEPTH(ASTX_FLAG_DELAY)
   ) u_free (
      .clk     (clk),
      .reset_n (reset_n),
      .din     (free_raw),
      .dout    (free_flag)
   );

   // decoded enables
   always_comb begin
      port_on    = st.ctrl[ASTX_CT_PORT_ON];
      async_mode = !st.ctrl[ASTX_CT_CLOCKED];
      // receive requests beat transmit in clocked mode
      tx_on = st.ctrl[ASTX_CT_TX_ENABLE] && port_on &&
              !(!async_mode && (st.ctrl[ASTX_CT_SINGLE_RECEIVE_EN] ||
                                st.ctrl[ASTX_CT_CONTINUOUS_RECEIVE_EN]));
      free_raw  = tx_on && !st.hold_full;
      wr_access = psel && penable && pwrite;
      rd_access = psel && penable && !pwrite;
   end

   // one process for bus, queue, shifter and interrupt
   always_comb begin
      next_st         = st;
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
      restart         = 1'b0;
      line_bit        = 1'b1;

      // register writes; free flag and empty bit are not writable
      if (wr_access && !st.pready) begin
         next_st.pready = 1'b1;
         unique case (paddr)
            ASTX_ADDR_DATA: begin
               if (tx_on) begin
                  next_st.hold_data = pwdata[ASTX_DATA_BITS-1:0];
                  next_st.hold_ninth = st.ninth_bit;
                  next_st.hold_full  = 1'b1;
               end
            end
            ASTX_ADDR_STATUS: begin
               next_st.ninth_bit = pwdata[ASTX_ST_NINTH];
               next_st.nine_en   = pwdata[ASTX_ST_NINE_EN];
            end
            ASTX_ADDR_CONTROL: next_st.ctrl = pwdata[6:0];
            ASTX_ADDR_BAUD:    next_st.baud = pwdata[ASTX_BAUD_W-1:0];
            ASTX_ADDR_IRQ_ST:  next_st.ev_status = st.ev_status;
            ASTX_ADDR_IRQ_EN:  next_st.ev_mask = pwdata[ASTX_EVENTS-1:0];
            default:           next_st.pslverr = 1'b1;
         endcase
      end

      // register reads
      if (rd_access && !st.pready) begin
         next_st.pready = 1'b1;
         next_st.prdata = '0;
         unique case (paddr)
            ASTX_ADDR_DATA: next_st.prdata[7:0] = st.hold_data;
            ASTX_ADDR_STATUS: begin
               next_st.prdata[ASTX_ST_NINTH]   = st.ninth_bit;
               next_st.prdata[ASTX_ST_EMPTY]   =
                  (st.phase == ASTX_IDLE);
               next_st.prdata[ASTX_ST_NINE_EN] = st.nine_en;
               next_st.prdata[ASTX_ST_FREE]    = free_flag;
            end
            ASTX_ADDR_CONTROL: next_st.prdata[6:0] = st.ctrl;
            ASTX_ADDR_BAUD: next_st.prdata[ASTX_BAUD_W-1:0] = st.baud;
            ASTX_ADDR_IRQ_ST: begin
               next_st.prdata[ASTX_EVENTS-1:0] = st.ev_status;
               next_st.ev_status = '0; // read clears
            end
            ASTX_ADDR_IRQ_EN:
               next_st.prdata[ASTX_EVENTS-1:0] = st.ev_mask;
            default: next_st.pslverr = 1'b1;
         endcase
      end

      // shifter; a load uses the same cycle as the stop end
      unique case (st.phase)
         ASTX_IDLE: begin
            line_bit = 1'b1;
            if (st.hold_full && tx_on) begin
               next_st.shift = {st.hold_ninth, st.hold_data};
               next_st.hold_full = 1'b0;
               next_st.phase = ASTX_START;
               restart = 1'b1;
            end
         end
         ASTX_START: begin
            line_bit = 1'b0;
            if (tick) begin
               next_st.phase   = ASTX_DATA;
               next_st.bit_cnt = '0;
            end
         end
         ASTX_DATA: begin
            line_bit = st.shift[0];
            if (tick) begin
               next_st.shift = {1'b0, st.shift[ASTX_DATA_BITS:1]};
               next_st.bit_cnt = st.bit_cnt + 4'h1;
               if (st.bit_cnt == 4'(ASTX_DATA_BITS - 1) + 4'(st.nine_en))
                  next_st.phase = ASTX_STOP;
            end
         end
         ASTX_STOP: begin
            line_bit = 1'b1;
            if (tick) begin
               next_st.ev_status[ASTX_EV_DONE] = 1'b1;
               // pending character moves in without an idle gap
               if (st.hold_full && tx_on) begin
                  next_st.shift = {st.hold_ninth, st.hold_data};
                  next_st.hold_full = 1'b0;
                  next_st.phase = ASTX_START;
                  restart = 1'b1;
               end else begin
                  next_st.phase = ASTX_IDLE;
               end
            end
         end
      endcase

      // disabled port: shifter idle, queue dropped, line idle
      if (!tx_on) begin
         next_st.phase     = ASTX_IDLE;
         next_st.hold_full = 1'b0;
         line_bit          = 1'b1;
      end

      // inversion only in asynchronous mode
      next_st.tx_out = (async_mode && st.ctrl[ASTX_CT_INVERT]) ?
                       !line_bit : line_bit;
      next_st.tx_oe_n = !port_on;

      // free event on rising flag; set wins over read clear
      next_st.free_prev = free_flag;
      if (free_flag && !st.free_prev)
         next_st.ev_status[ASTX_EV_FREE] = 1'b1;

      // level request: enable gates the flag, flag itself ungated
      next_st.irq = (st.ctrl[ASTX_CT_IRQ_EN] && free_flag) ||
                    |(next_st.ev_status & st.ev_mask);
   end

   // state register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st         <= '0;
         st.tx_out  <= 1'b1;
         st.tx_oe_n <= 1'b1;
         st.baud    <= ASTX_BAUD_RESET;
         st.phase   <= ASTX_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign prdata  = st.prdata;
   assign pready  = st.pready;
   assign pslverr = st.pslverr;
   assign tx_out  = st.tx_out;
   assign tx_oe_n = st.tx_oe_n;
   assign irq     = st.irq;
endmodule

// >>> astx_top_asserts.sv
// port-level checker for the serial transmitter, bound to its top
`timescale 1ns/10ps
module astx_chk
   import astx_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        reset_n,
   // apb side
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   // line and interrupt
   input wire logic        tx_out,
   input wire logic        tx_oe_n,
   input wire logic        irq
);
   logic [6:0]  ctl;
   logic [15:0] baud;
   logic [3:0]  age;
   logic        prev_tx;
   int          run;
   int          idl;
   // shadow settings; polarity only counts in asynchronous mode
   wire wr   = pready && pwrite;
   wire en   = ctl[0] && ctl[2] && !ctl[1];
   wire idle = !(ctl[3] && !ctl[1]);
   wire lng  = idl > 10 * (int'(baud) + 1); // longer than ten bit periods, the longest idle-level run in a frame
   // any write restarts quiet time: shifter state is unknown after it
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctl     <= 7'h00;
         baud    <= ASTX_BAUD_RESET;
         age     <= 4'h0;
         prev_tx <= 1'b1;
         run     <= 0;
         idl     <= 0;
      end else begin
         prev_tx <= tx_out;
         run     <= (tx_out != prev_tx) ? 1 : run + 1;
         idl     <= (tx_out != idle || wr) ? 0 : idl + 1;
         age     <= wr ? 4'h0 : age + {3'h0, age != 4'hF};
         if (wr && paddr == ASTX_ADDR_CONTROL)
            ctl <= pwdata[6:0];
         if (wr && paddr == ASTX_ADDR_BAUD)
            baud <= pwdata[15:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_rd_st;
      pready && !pwrite && paddr == ASTX_ADDR_STATUS && age > 2;
   endsequence
   sequence s_wr_idle;
      wr && paddr == ASTX_ADDR_DATA && en && lng && age > 3;
   endsequence
   property p_line_off;
      age > 3 && !en |-> tx_out == idle;
   endproperty
   a_line_off: assert property (p_line_off)
      else $error("line not idle while disabled");
   property p_oe;
      age > 3 |-> tx_oe_n == !ctl[2];
   endproperty
   a_oe: assert property (p_oe)
      else $error("driver enable does not follow port on");
   property p_start;
      s_wr_idle |-> ##[1:4] tx_out != idle;
   endproperty
   a_start: assert property (p_start)
      else $error("no start bit after write to idle shifter");
   property p_bit;
      en && age > 4 && tx_out == idle && prev_tx != idle
         |-> run % (int'(baud) + 1) == 0;
   endproperty
   a_bit: assert property (p_bit)
      else $error("bit time not a whole baud period");
   property p_st_idle;
      s_rd_st ##0 (en && lng) |-> prdata[ASTX_ST_EMPTY] &&
         prdata[ASTX_ST_FREE];
   endproperty
   a_st_idle: assert property (p_st_idle)
      else $error("idle status not free and empty");
   property p_st_busy;
      s_rd_st ##0 (en && tx_out != idle && prev_tx != idle)
         |-> !prdata[ASTX_ST_EMPTY];
   endproperty
   a_st_busy: assert property (p_st_busy)
      else $error("shift empty set mid frame");
   property p_free_off;
      s_rd_st ##0 !(ctl[0] && ctl[2]) |-> !prdata[ASTX_ST_FREE];
   endproperty
   a_free_off: assert property (p_free_off)
      else $error("free flag set while disabled");
   property p_irq_on;
      age > 3 && en && ctl[6] && lng |-> irq;
   endproperty
   a_irq_on: assert property (p_irq_on)
      else $error("no interrupt with enable and free buffer");
endmodule
bind astx_top astx_chk u_chk (.clk, .reset_n, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .tx_out, .tx_oe_n, .irq);

// >>> astx_rx_model.sv
// far-end receiver model that decodes frames on the line
`timescale 1ns/10ps
module astx_rx_model #(
   parameter int BIT = 4
) (
   // clock and normalised line
   input  wire logic  clk,
   input  wire logic  line,
   input  wire logic  nine,
   // last frame decoded
   output logic [8:0] word,
   output logic       bad,
   output int         count
);
   // a low shorter than half a bit is a glitch and is dropped
   initial begin
      word  = 9'h000;
      bad   = 1'b0;
      count = 0;
      forever begin
         @(posedge clk);
         if (!line) begin
            repeat (BIT / 2) @(posedge clk);
            // outputs move by non-blocking update: the bench sees them
            // one edge later instead of racing the model at the edge
            if (!line) begin
               word <= 9'h000;
               for (int i = 0; i < 8 + nine; i++) begin
                  repeat (BIT) @(posedge clk);
                  word[i] <= line;
               end
               repeat (BIT) @(posedge clk);
               bad   <= !line;
               count <= count + 1;
            end
         end
      end
   end
endmodule

// >>> test_async_serial_transmitter.sv
// self-checking bench for the serial transmitter
`timescale 1ns/10ps
module test_async_serial_transmitter;
   import astx_pkg::*;
   localparam int BAUD = 3;
   logic        clk, reset_n, psel, penable, pwrite, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, tx_out, tx_oe_n, irq, inv, nine, bad;
   logic [8:0]  word;
   int          count, n_mismatch, comparisons;
   logic [7:0]  ad [5] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
   logic [31:0] ex [5] = '{32'h2, 32'h0, 32'hD9, 32'h0, 32'h0};
   // released line is pulled up; model sees true polarity
   wire         line = (tx_oe_n ? 1'b1 : tx_out) ^ inv;
   astx_top dut_u (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .tx_out, .tx_oe_n, .irq);
   astx_rx_model #(.BIT(BAUD + 1)) rx_u (.clk, .line, .nine, .word,
      .bad, .count);
   task automatic summarize;
      $display("checks %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask
   // one transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (!pready && k < 20);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (!pready) begin
         n_mismatch++;
         summarize();
      end
      @(posedge clk);
   endtask
   task automatic wait_rx(input int n);
      int k;
      k = 0;
      while (count < n && k < 400) begin
         @(posedge clk);
         k++;
      end
      if (count < n) begin
         n_mismatch++;
         summarize();
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      inv = 1'b0;
      nine = 1'b0;
      n_mismatch = 0;
      comparisons = 0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      foreach (ad[i]) begin
         apb(1'b1 ^ 1'b1, ad[i], 32'h0);
         chk("reset", ex[i], rd);
      end
      chk("oe_n", 1, tx_oe_n);
      $display("test reset done");
      apb(1'b0, 8'h18, 32'h0);
      chk("slverr", 1, err);
      apb(1'b1, ASTX_ADDR_DATA, 32'h55);
      repeat (60) @(posedge clk);
      chk("frames", 0, count);
      $display("test refuse done");
      apb(1'b1, ASTX_ADDR_BAUD, BAUD);
      apb(1'b1, ASTX_ADDR_CONTROL, 32'h5);
      chk("oe_n", 0, tx_oe_n);
      apb(1'b1, ASTX_ADDR_STATUS, 32'h41);
      nine = 1'b1;
      apb(1'b0, ASTX_ADDR_STATUS, 32'h0);
      chk("status", 32'hC3, rd);
      $display("test status done");
      repeat (48) @(posedge clk);
      apb(1'b1, ASTX_ADDR_DATA, 32'hA5);
      wait_rx(1);
      chk("word", 32'h1A5, word);
      chk("stop", 0, bad);
      apb(1'b1, ASTX_ADDR_DATA, 32'h3C);
      apb(1'b1, ASTX_ADDR_DATA, 32'hC3);
      apb(1'b0, ASTX_ADDR_STATUS, 32'h0);
      chk("status", 32'h41, rd);
      wait_rx(2);
      chk("word", 32'h13C, word);
      wait_rx(3);
      chk("word", 32'h1C3, word);
      repeat (40) @(posedge clk);
      apb(1'b0, ASTX_ADDR_STATUS, 32'h0);
      chk("status", 32'hC3, rd);
      $display("test frames done");
      apb(1'b0, ASTX_ADDR_IRQ_ST, 32'h0);
      apb(1'b1, ASTX_ADDR_CONTROL, 32'h45);
      repeat (48) @(posedge clk);
      chk("irq", 1, irq);
      apb(1'b1, ASTX_ADDR_CONTROL, 32'h5);
      apb(1'b1, ASTX_ADDR_IRQ_EN, 32'h2);
      chk("irq", 0, irq);
      apb(1'b1, ASTX_ADDR_DATA, 32'h0F);
      wait_rx(4);
      repeat (10) @(posedge clk);
      chk("irq", 1, irq);
      apb(1'b0, ASTX_ADDR_IRQ_ST, 32'h0);
      chk("event", 32'h2, rd & 32'h2);
      chk("irq", 0, irq);
      $display("test irq done");
      apb(1'b1, ASTX_ADDR_CONTROL, 32'hD);
      inv = 1'b1;
      chk("idle", 0, tx_out);
      apb(1'b1, ASTX_ADDR_DATA, 32'h5A);
      wait_rx(5);
      chk("word", 32'h15A, word);
      $display("test polarity done");
      apb(1'b1, ASTX_ADDR_DATA, 32'hFF);
      repeat (10) @(posedge clk);
      apb(1'b1, ASTX_ADDR_CONTROL, 32'h8);
      inv = 1'b0;
      repeat (4) @(posedge clk);
      chk("idle", 0, tx_out);
      chk("oe_n", 1, tx_oe_n);
      apb(1'b0, ASTX_ADDR_STATUS, 32'h0);
      chk("status", 32'h43, rd);
      apb(1'b1, ASTX_ADDR_STATUS, 32'hC1);
      apb(1'b0, ASTX_ADDR_STATUS, 32'h0);
      chk("status", 32'h43, rd);
      // clocked mode with a receive request: no frame, no inversion
      apb(1'b1, ASTX_ADDR_CONTROL, 32'h1F);
      apb(1'b1, ASTX_ADDR_DATA, 32'h77);
      repeat (2) @(posedge clk);
      chk("sync_line", 1, tx_out);
      apb(1'b0, ASTX_ADDR_STATUS, 32'h0);
      chk("status", 32'h43, rd);
      $display("test disable done");
      summarize();
   end
endmodule
